/* design/vic_defines.svh */
// Constants of the vectored interrupt controller
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ----------------------------------------------------------------
// Source counts and vector table layout
// ----------------------------------------------------------------
`define VIC_NUM_IRQ 67
`define VIC_NUM_TRAP 5
`define VIC_TRAP_SLOTS 7'h08
`define VIC_TABLE_ENTRIES 7'h7e
`define VIC_PRI_TABLE_BASE 24'h000004
`define VIC_ENTRY_STRIDE 24'h000002
`define VIC_ALT_TABLE_BASE (`VIC_PRI_TABLE_BASE + 24'(`VIC_TABLE_ENTRIES) * `VIC_ENTRY_STRIDE)
`define VIC_ALT_SELECT_BIT 15
`define VIC_RESET_ADDR 24'h000000

// ----------------------------------------------------------------
// Priority levels and fixed latencies
// ----------------------------------------------------------------
`define VIC_TRAP_TOP_LEVEL 4'hf
`define VIC_MAX_USER_LEVEL 4'h7
`define VIC_ENTRY_CYCLES 3
`define VIC_RETURN_CYCLES 2'h3

`endif

/* design/vic_pkg.sv */
// Types shared by the vectored interrupt controller
package vic_pkg;
   typedef logic [6:0] vic_vec_t;
   typedef logic [3:0] vic_lvl_t;
   typedef logic [2:0] vic_upri_t;
   typedef logic [23:0] vic_addr_t;
   typedef enum logic [1:0] {VIC_IDLE, VIC_READ, VIC_LOAD} vic_fetch_state_t;
endpackage

/* design/vic_fetch.sv */
// Vector fetch sequencer: reads the chosen table entry from program memory
`timescale 1ns/1ns
`include "vic_defines.svh"
module vic_fetch
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Accepted request
   input wire logic take,
   input wire vic_vec_t take_num,
   input wire logic alt_sel,
   // Program memory read port, data one cycle after pm_rd
   output logic pm_rd,
   output vic_addr_t pm_addr,
   input wire vic_addr_t pm_rdata,
   // Result to the core
   output logic busy,
   output vic_vec_t vec_num,
   output logic vec_valid,
   output vic_addr_t service_routine_addr
);

   // ----------------------------------------------------------------
   // Entry address of a vector in the selected table
   // ----------------------------------------------------------------
   function automatic vic_addr_t entry_addr(input logic alt, input vic_vec_t num);
      entry_addr = (alt ? `VIC_ALT_TABLE_BASE : `VIC_PRI_TABLE_BASE)
                   + `VIC_ENTRY_STRIDE * 24'(num);
   endfunction

   vic_fetch_state_t state;
   vic_fetch_state_t next_state;

   assign pm_rd = (state == VIC_READ);
   assign busy = (state != VIC_IDLE);

   always_comb
   begin
      unique case (state)
         VIC_IDLE: next_state = take ? VIC_READ : VIC_IDLE;
         VIC_READ: next_state = VIC_LOAD;
         VIC_LOAD: next_state = VIC_IDLE;
         default: next_state = VIC_IDLE;
      endcase
   end

   // Same three steps for every source, so entry latency never varies
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state <= VIC_IDLE;
         vec_num <= 7'h00;
         pm_addr <= `VIC_RESET_ADDR;
         vec_valid <= 1'b0;
         service_routine_addr <= `VIC_RESET_ADDR;
      end
      else
      begin
         state <= next_state;
         vec_valid <= (state == VIC_LOAD);
         if (state == VIC_IDLE && take)
         begin
            vec_num <= take_num;
            pm_addr <= entry_addr(alt_sel, take_num);
         end
         if (state == VIC_LOAD)
            service_routine_addr <= pm_rdata;
      end
   end
endmodule

/* design/vic_ctrl.sv */
// Vectored interrupt controller: arbitration, request to the core, vector fetch
`timescale 1ns/1ns
`include "vic_defines.svh"
module vic_ctrl
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Interrupt sources, all from logic on sys_clk
   input wire logic [`VIC_NUM_IRQ-1:0] irq_flag,
   input wire logic [`VIC_NUM_IRQ-1:0] irq_enable,
   input wire logic [3*`VIC_NUM_IRQ-1:0] irq_level,
   input wire logic [`VIC_NUM_TRAP-1:0] trap_flag,
   // Control register 2 contents
   input wire logic [15:0] interrupt_control_reg_2,
   // Core side
   input wire vic_lvl_t core_ipl,
   input wire logic core_take,
   input wire logic core_return,
   output logic core_irq,
   output vic_vec_t win_num,
   output vic_vec_t vec_num,
   output logic vec_valid,
   output vic_addr_t service_routine_addr,
   output logic return_done,
   // Program memory read port
   output logic pm_rd,
   output vic_addr_t pm_addr,
   input wire vic_addr_t pm_rdata
);

   // ----------------------------------------------------------------
   // Per-source effective levels
   // ----------------------------------------------------------------
   function automatic vic_lvl_t user_level(input logic flag, input logic en,
                                           input vic_upri_t upri);
      user_level = (flag && en) ? {1'b0, upri} : 4'h0;
   endfunction

   // Traps sit above every user level, lower slot higher
   function automatic vic_lvl_t trap_level(input logic flag, input int idx);
      trap_level = flag ? `VIC_TRAP_TOP_LEVEL - 4'(idx) : 4'h0;
   endfunction

   vic_lvl_t irq_lvl [`VIC_NUM_IRQ];
   vic_lvl_t trp_lvl [`VIC_NUM_TRAP];

   for (genvar i = 0; i < `VIC_NUM_IRQ; i++)
   begin : g_irq
      assign irq_lvl[i] = user_level(irq_flag[i], irq_enable[i], irq_level[3*i +: 3]);
   end
   for (genvar t = 0; t < `VIC_NUM_TRAP; t++)
   begin : g_trap
      assign trp_lvl[t] = trap_level(trap_flag[t], t);
   end

   // ----------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------
   vic_lvl_t win_lvl;
   vic_vec_t next_win;
   vic_lvl_t next_lvl;

   // Scan from the highest position down with >=, so a lower position
   // overrides on a tie; fixed order keeps latency and timing static
   always_comb
   begin
      next_lvl = 4'h0;
      next_win = 7'h00;
      for (int i = `VIC_NUM_IRQ - 1; i >= 0; i--)
      begin
         if (irq_lvl[i] != 4'h0 && irq_lvl[i] >= next_lvl)
         begin
            next_lvl = irq_lvl[i];
            next_win = `VIC_TRAP_SLOTS + 7'(i);
         end
      end
      for (int t = `VIC_NUM_TRAP - 1; t >= 0; t--)
      begin
         if (trp_lvl[t] != 4'h0 && trp_lvl[t] >= next_lvl)
         begin
            next_lvl = trp_lvl[t];
            next_win = 7'(t);
         end
      end
   end

   assign win_lvl = next_lvl;
   assign win_num = next_win;

   // ----------------------------------------------------------------
   // Request to the core and fetch
   // ----------------------------------------------------------------
   logic fetch_busy;
   logic ret_busy;
   logic alt_sel;
   logic take;
   logic [1:0] ret_cnt;

   assign alt_sel = interrupt_control_reg_2[`VIC_ALT_SELECT_BIT];
   // No new request while a vector is being fetched or a return runs
   assign core_irq = (win_lvl > core_ipl) && !fetch_busy && !ret_busy;
   assign take = core_take && core_irq;
   assign ret_busy = (ret_cnt != 2'h0);

   vic_fetch u_fetch (
      .sys_clk(sys_clk),
      .rst(rst),
      .take(take),
      .take_num(win_num),
      .alt_sel(alt_sel),
      .pm_rd(pm_rd),
      .pm_addr(pm_addr),
      .pm_rdata(pm_rdata),
      .busy(fetch_busy),
      .vec_num(vec_num),
      .vec_valid(vec_valid),
      .service_routine_addr(service_routine_addr)
   );

   // ----------------------------------------------------------------
   // Return timing
   // ----------------------------------------------------------------
   // Reset only clears this block; it never raises a vector request
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ret_cnt <= 2'h0;
         return_done <= 1'b0;
      end
      else
      begin
         // Pulse in the last counted cycle, so done lands three edges after the start
         return_done <= (ret_cnt == 2'h2);
         if (ret_cnt != 2'h0)
            ret_cnt <= ret_cnt - 2'h1;
         else if (core_return && !fetch_busy)
            ret_cnt <= `VIC_RETURN_CYCLES;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   vic_addr_t exp_addr;
   assign exp_addr = (alt_sel ? `VIC_ALT_TABLE_BASE : `VIC_PRI_TABLE_BASE)
                     + `VIC_ENTRY_STRIDE * 24'(win_num);

   sequence s_accept;
      core_take && core_irq;
   endsequence
   sequence s_fetch;
      pm_rd && !vec_valid ##1 !pm_rd && !vec_valid;
   endsequence
   sequence s_return_run;
      !return_done ##1 !return_done ##1 return_done;
   endsequence

   chk_irq_merge: assert property (irq_flag[0] && irq_enable[0]
      && irq_level[2:0] != 3'h0 && core_ipl == 4'h0 && !fetch_busy && !ret_busy
      |-> core_irq) else $error("pending source not requested");
   chk_irq_above: assert property (core_irq |-> win_lvl > core_ipl)
      else $error("request at or below core priority");
   chk_trap_first: assert property (|trap_flag |-> win_num < `VIC_TRAP_SLOTS)
      else $error("maskable source beat a trap");
   chk_core_pri: assert property (|trap_flag && core_irq
      |-> win_lvl > `VIC_MAX_USER_LEVEL) else $error("trap not above user levels");
   chk_user_level: assert property (core_irq && win_num >= `VIC_TRAP_SLOTS
      |-> win_lvl <= `VIC_MAX_USER_LEVEL) else $error("user level out of range");
   // A new accept may fall in a vector pulse cycle, so that cycle is not checked
   chk_entry_fixed: assert property (s_accept |=> s_fetch ##1 vec_valid)
      else $error("entry latency not fixed");
   chk_entry_quiet: assert property (s_accept |=> !core_irq [*2])
      else $error("request raised during fetch");
   chk_read_once: assert property (pm_rd |=> !pm_rd)
      else $error("table read longer than one cycle");
   chk_return_fixed: assert property (core_return && !ret_busy && !fetch_busy
      |=> s_return_run) else $error("return latency not fixed");
   chk_table_addr: assert property (s_accept && !alt_sel && win_num == 7'h00
      |=> pm_addr == `VIC_PRI_TABLE_BASE) else $error("main table base misplaced");
   // The alternate base is rebuilt here from the table size, not taken from its macro
   chk_alt_follow: assert property (s_accept && alt_sel && win_num == 7'h00
      |=> pm_addr == `VIC_PRI_TABLE_BASE + 24'(`VIC_TABLE_ENTRIES) * `VIC_ENTRY_STRIDE)
      else $error("alternate table not after main table");
   chk_fetch_addr: assert property (s_accept
      |=> pm_addr == $past(exp_addr)) else $error("wrong table entry address");
   chk_vec_data: assert property (pm_rd
      |=> ##1 service_routine_addr == $past(pm_rdata))
      else $error("routine address not from table");
   chk_zero_wins: assert property (trap_flag[0] |-> win_num == 7'h00)
      else $error("slot 0 lost arbitration");
   // Only the nearest lower neighbour is checked; a full scan would repeat the arbiter
   chk_tie_lower: assert property (core_irq && win_num > `VIC_TRAP_SLOTS
      |-> irq_lvl[7'(win_num - `VIC_TRAP_SLOTS - 7'h01)] < win_lvl
          || irq_lvl[7'(win_num - `VIC_TRAP_SLOTS - 7'h01)] > win_lvl)
      else $error("lower neighbour at same level lost");
   chk_vec_range: assert property (core_irq |-> win_num < `VIC_TABLE_ENTRIES)
      else $error("vector outside table");

   // Reset leaves no stale pulse for the core to act on
   chk_reset_quiet: assert property ($past(rst) |-> !vec_valid && !return_done)
      else $error("pulse right after reset");
endmodule

/* testbench/vic_core_model.sv */
// Model of the processor core and program memory facing the controller
`timescale 1ns/1ns
module vic_core_model
   import vic_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Request handshake
   input wire logic core_irq,
   input wire logic take_en,
   input wire logic slow,
   output logic core_take,
   // Program memory read port
   input wire logic pm_rd,
   input wire vic_addr_t pm_addr,
   output vic_addr_t pm_rdata
);
   logic armed;

   // ----------------------------------------------------------------
   // Accept pulse and table read
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         armed <= 1'b0;
         core_take <= 1'b0;
         pm_rdata <= 24'h5a5a5a;
      end
      else
      begin
         // A slow core lets the request stand one extra cycle before taking it
         armed <= take_en & core_irq;
         core_take <= take_en & core_irq & ~core_take & (armed | ~slow);
         // Word is valid for one cycle only; otherwise it keeps toggling
         if (pm_rd)
            pm_rdata <= pm_addr ^ 24'h3c5a00;
         else
            pm_rdata <= ~pm_rdata;
      end
   end
endmodule

/* testbench/tb_vic_ctrl.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
`include "vic_defines.svh"
module tb_vic_ctrl import vic_pkg::*;;
   typedef struct {
      vic_vec_t ia, ib, evec;
      logic [2:0] la, lb;
      logic ena, alt, eirq;
      logic [4:0] tr;
      vic_lvl_t ipl;
   } vic_row_t;
   // Sources a and b (7f = none), expected winner, levels, enable of a, table, request
   vic_row_t rows [13] = '{
      '{7'h00, 7'h7f, 7'h08, 3'h1, 3'h0, 1, 0, 1, 5'h00, 4'h0},
      '{7'h42, 7'h00, 7'h08, 3'h7, 3'h7, 1, 0, 1, 5'h00, 4'h0},
      '{7'h42, 7'h00, 7'h4a, 3'h7, 3'h6, 1, 0, 1, 5'h00, 4'h0},
      '{7'h05, 7'h7f, 7'h00, 3'h3, 3'h0, 1, 0, 0, 5'h00, 4'h3},
      '{7'h05, 7'h7f, 7'h0d, 3'h4, 3'h0, 1, 0, 1, 5'h00, 4'h3},
      '{7'h00, 7'h7f, 7'h04, 3'h7, 3'h0, 1, 0, 1, 5'h10, 4'h7},
      '{7'h7f, 7'h7f, 7'h00, 3'h0, 3'h0, 1, 0, 1, 5'h1f, 4'h0},
      '{7'h42, 7'h7f, 7'h4a, 3'h2, 3'h0, 1, 1, 1, 5'h00, 4'h0},
      '{7'h7f, 7'h7f, 7'h00, 3'h0, 3'h0, 1, 1, 1, 5'h01, 4'h0},
      '{7'h0a, 7'h7f, 7'h00, 3'h5, 3'h0, 0, 0, 0, 5'h00, 4'h0},
      '{7'h0a, 7'h7f, 7'h00, 3'h0, 3'h0, 1, 0, 0, 5'h00, 4'h0},
      '{7'h03, 7'h7f, 7'h00, 3'h5, 3'h0, 1, 0, 0, 5'h02, 4'he},
      '{7'h03, 7'h7f, 7'h01, 3'h5, 3'h0, 1, 0, 1, 5'h02, 4'hd}};
   logic sys_clk = 0, rst = 1, core_return = 0, take_en = 0, slow = 0;
   logic [66:0] irq_flag = '0, irq_enable = '1, f, e;
   logic [200:0] irq_level = '0, l;
   logic [4:0] trap_flag = '0;
   logic [15:0] interrupt_control_reg_2 = '0;
   vic_lvl_t core_ipl = '0;
   logic core_take, core_irq, vec_valid, return_done, pm_rd;
   vic_vec_t win_num, vec_num;
   vic_addr_t service_routine_addr, pm_addr, pm_rdata;
   int miscompares = 0, tests_run = 0, cycles = 0, hits;

   vic_ctrl DUT (.sys_clk, .rst, .irq_flag, .irq_enable, .irq_level, .trap_flag,
      .interrupt_control_reg_2, .core_ipl, .core_take, .core_return, .core_irq, .win_num,
      .vec_num, .vec_valid, .service_routine_addr, .return_done, .pm_rd, .pm_addr, .pm_rdata);
   vic_core_model core (.sys_clk, .rst, .core_irq, .take_en, .slow, .core_take, .pm_rd,
      .pm_addr, .pm_rdata);

   always #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Takes the pending request, checks the fetched vector, then runs a return
   task automatic accept(input vic_vec_t v, input logic alt);
      vic_addr_t entry;
      int n;
      int rd;
      entry = (alt ? `VIC_ALT_TABLE_BASE : `VIC_PRI_TABLE_BASE) + 24'(v) * `VIC_ENTRY_STRIDE;
      @(posedge sys_clk) take_en <= 1'b1;
      repeat (6) if (core_take !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk) take_en <= 1'b0;
      n = 0;
      rd = 0;
      while (vec_valid !== 1'b1 && n < 8)
      begin
         @(negedge sys_clk);
         n++;
         rd += int'(pm_rd);
      end
      check("entry cycles", `VIC_ENTRY_CYCLES, n);
      check("read strobes", 1, rd);
      check("vector number", v, vec_num);
      check("entry address", entry, pm_addr);
      check("routine address", entry ^ 24'h3c5a00, service_routine_addr);
      @(posedge sys_clk) core_return <= 1'b1;
      @(posedge sys_clk) core_return <= 1'b0;
      n = 0;
      rd = 0;
      while (return_done !== 1'b1 && n < 8)
      begin
         @(negedge sys_clk);
         n++;
         rd += int'(core_irq);
      end
      check("return cycles", `VIC_RETURN_CYCLES, n);
      check("request during return", 0, rd);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         miscompares++;
         final_report();
      end
   end

   initial
   begin
      repeat (11) @(posedge sys_clk);
      @(negedge sys_clk);
      check("reset flags", 0, {vec_valid, pm_rd, return_done, vec_num});
      check("reset addresses", 0, pm_addr | service_routine_addr);
      @(posedge sys_clk) rst <= 1'b0;
      for (int i = 0; i < 13; i++)
      begin
         f = '0;
         e = '1;
         l = '0;
         if (rows[i].ia != 7'h7f)
         begin
            f[rows[i].ia] = 1'b1;
            e[rows[i].ia] = rows[i].ena;
            l[3*rows[i].ia +: 3] = rows[i].la;
         end
         if (rows[i].ib != 7'h7f)
         begin
            f[rows[i].ib] = 1'b1;
            l[3*rows[i].ib +: 3] = rows[i].lb;
         end
         @(posedge sys_clk)
         begin
            irq_flag <= f;
            irq_enable <= e;
            irq_level <= l;
            trap_flag <= rows[i].tr;
            core_ipl <= rows[i].ipl;
            interrupt_control_reg_2 <= {rows[i].alt, 15'h7fff};
            slow <= i[0];
         end
         @(negedge sys_clk);
         check("request", rows[i].eirq, core_irq);
         if (rows[i].eirq)
         begin
            check("winner", rows[i].evec, win_num);
            accept(rows[i].evec, rows[i].alt);
         end
      end
      // Reset in mid-fetch must not let a vector out
      @(posedge sys_clk)
      begin
         irq_flag <= '0;
         trap_flag <= 5'h08;
         core_ipl <= 4'h0;
         take_en <= 1'b1;
      end
      repeat (6) if (core_take !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk)
      begin
         rst <= 1'b1;
         take_en <= 1'b0;
      end
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      hits = 0;
      repeat (6) @(negedge sys_clk) hits += int'(vec_valid);
      check("vectors after reset", 0, hits);
      check("number after reset", 0, vec_num);
      final_report();
   end
endmodule
